// ---- bench/ccv_afe_model.sv ----
/*
 Far-side model: CC line and VBUS sense comparators.
 Assumes line levels given by the bench as DAC codes.
*/
`timescale 1ns/1ps
module ccv_afe_model
   import ccv_pkg::*;
(
   // Control from the block
   input wire ccv_comp_ctl_t cc_comp_ctl,
   input wire logic [7:0] vbus_dac_code,
   // Line levels from the bench
   input wire logic [1:0][7:0] cc_lvl,
   input wire logic [7:0] vbus_lvl,
   // Comparator results
   output logic cc_comp,
   output logic vbus_comp
);
   // Ideal comparators; no hysteresis, so edges are exact
   always_comb begin
      cc_comp = cc_lvl[cc_comp_ctl.pin] > cc_comp_ctl.dac_code;
      vbus_comp = vbus_lvl > vbus_dac_code;
   end
endmodule

// ---- bench/ccv_top_assertions.sv ----
/*
 Port-level checks of the bus slave, reset state and termination outputs.
 Assumes binding to ccv_top, one clock domain.
*/
`timescale 1ns/1ps
module ccv_top_chk
   import ccv_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire ccv_comp_ctl_t cc_comp_ctl,
   input wire logic [7:0] vbus_dac_code,
   input wire ccv_pd_out_t [1:0] pd_ctl,
   input wire logic [1:0][1:0] rp_level,
   input wire logic [1:0] vconn_fet,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_hresp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_wait_entry: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout)
      else $error("no wait state after transfer");
   a_wait_single: assert property (!hreadyout |=> hreadyout)
      else $error("wait state too long");
   a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> vconn_fet == 2'h0 && !irq && hreadyout)
      else $error("outputs active after reset");
   a_dead_batt_default: assert property ($rose(rstn) |-> !pd_ctl[0].dead_battery_pulldown_enable_n && !pd_ctl[1].dead_battery_pulldown_enable_n)
      else $error("dead battery pull-down off after reset");
   a_rp_reset_zero: assert property ($rose(rstn) |-> rp_level == 4'h0 && cc_comp_ctl == '0)
      else $error("Rp or comparator active after reset");
   a_rd_one_kind: assert property (pd_ctl[0].en_rd_trim |-> pd_ctl[0].dead_battery_pulldown_enable_n)
      else $error("both pull-downs on CC1");
   a_rdata_hold: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
      else $error("read data moved outside data phase");
   a_dac_by_write: assert property (!$stable(vbus_dac_code) |-> $past(hreadyout) == 1'b0)
      else $error("VBUS DAC code moved without write");
endmodule
bind ccv_top ccv_top_chk u_chk (.clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cc_comp_ctl(cc_comp_ctl),
   .vbus_dac_code(vbus_dac_code), .pd_ctl(pd_ctl), .rp_level(rp_level), .vconn_fet(vconn_fet), .irq(irq));

// ---- bench/tb_top.sv ----
/*
 Register-level bench for the CC detect and VCONN block.
 Assumes the AHB-Lite slave, the front-end model and shortened debounce units.
*/
`timescale 1ns/1ps
module tb_top
   import ccv_pkg::*;
;
   logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, pd_busy = 0, vconn_oc = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0] htrans = 0, cc_backdrive = 0, vconn_fet;
   logic [1:0][7:0] cc_lvl = 0;
   logic [7:0] vbus_lvl = 0, vbus_dac_code;
   logic hreadyout, hresp, cc_comp, vbus_comp, irq;
   ccv_comp_ctl_t cc_comp_ctl;
   ccv_pd_out_t [1:0] pd_ctl;
   logic [1:0][1:0] rp_level;
   int num_errors = 0, total_checks = 0;
   always #25 clk = ~clk;
   // Short units keep debounce runs to a few thousand cycles
   ccv_top #(.UNIT_FAST(20), .UNIT_SLOW(40)) u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cc_comp(cc_comp), .pd_busy(pd_busy), .vconn_oc(vconn_oc),
      .cc_backdrive(cc_backdrive), .vbus_comp(vbus_comp), .cc_comp_ctl(cc_comp_ctl),
      .vbus_dac_code(vbus_dac_code), .pd_ctl(pd_ctl), .rp_level(rp_level), .vconn_fet(vconn_fet), .irq(irq));
   ccv_afe_model u_afe (.cc_comp_ctl(cc_comp_ctl), .vbus_dac_code(vbus_dac_code), .cc_lvl(cc_lvl),
      .vbus_lvl(vbus_lvl), .cc_comp(cc_comp), .vbus_comp(vbus_comp));
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      xfer(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wirq(input int n);
      for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
   endtask
   task summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      // Tests need about 9000 cycles; allow roughly four times that
      #(40000 * 50);
      num_errors++;
      summarize;
   end
   initial begin
      wt(2);
      rstn <= 1'b1;
      rchk(OFS_CC_CONTROL, 32'h28);
      chk(pd_ctl[1].dead_battery_pulldown_enable_n, 1'b0);
      wr(8'hf0, 32'h1);
      rchk(8'hf0, 32'h0);
      wr(OFS_CC_CONTROL, 32'h14);
      wt(1);
      chk(pd_ctl, 6'b110110);
      wr(OFS_CC_CONTROL, 32'h2d4);
      wt(1);
      chk(rp_level, 4'hb);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CC_CONTROL, 32'h14 | (32'h400 << i));
         wt(2);
         chk(vconn_fet, 2'h1 << i);
      end
      $display("test reset and termination done");
      wr(OFS_VBUS_CONTROL, 32'h140);
      wr(OFS_VCONN_FAULT_DEBOUNCE, 32'h2);
      wr(OFS_CC_CONTROL, 32'h414);
      vconn_oc <= 1'b1;
      wt(15);
      vconn_oc <= 1'b0;
      wt(3);
      chk(vconn_fet, 2'h1);
      rchk(OFS_PWR_STS, 32'h0, 32'h7);
      vconn_oc <= 1'b1;
      wt(100);
      vconn_oc <= 1'b0;
      chk(vconn_fet, 2'h0);
      chk(irq, 1'b1);
      rchk(OFS_PWR_STS, 32'h1, 32'h7);
      rchk(OFS_CC_CONTROL, 32'h14);
      wr(OFS_PWR_STS, 32'h1);
      rchk(OFS_PWR_STS, 32'h0, 32'h7);
      vbus_lvl <= 8'h60;
      rchk(OFS_VBUS_CONTROL, 32'h10140);
      chk(vbus_dac_code, 8'h40);
      vbus_lvl <= 8'h20;
      rchk(OFS_VBUS_CONTROL, 32'h140);
      $display("test vconn and vbus done");
      wr(OFS_CC_HW_CONTROL, 32'h3);
      wr(OFS_MATCH_DEBOUNCE_COUNT, 32'h4);
      wr(OFS_MATCH_EN, 32'h10);
      wr(OFS_SAMPLE_EN, 32'h10);
      wr(OFS_DBCLR_EN, 32'h10);
      wr(OFS_THR_BASE + 8'h10, 32'h80);
      cc_lvl[0] <= 8'hc0;
      wr(OFS_CC_CONTROL, 32'h15);
      wirq(4000);
      chk(irq, 1'b1);
      chk(cc_comp_ctl.dac_code, 8'h80);
      rchk(OFS_MATCH, 32'h10);
      rchk(OFS_CHG_STS, 32'h10);
      wr(OFS_CHG_STS, 32'h10);
      wt(2);
      chk(irq, 1'b0);
      // Traffic on the line must leave the old result in place
      pd_busy <= 1'b1;
      cc_lvl[0] <= 8'h10;
      wt(3000);
      rchk(OFS_MATCH, 32'h10);
      chk(irq, 1'b0);
      pd_busy <= 1'b0;
      wirq(4000);
      chk(irq, 1'b1);
      rchk(OFS_MATCH, 32'h0);
      rchk(OFS_PWR_STS, 32'h8, 32'h8);
      $display("test collision done");
      // VCONN discharge through threshold 0 with Ra on CC1
      wr(OFS_CC_CONTROL, 32'h0c);
      wr(OFS_THR_BASE, 32'h29);
      wr(OFS_DBCLR_EN, 32'h1);
      wr(OFS_MATCH_EN, 32'h1);
      wr(OFS_SAMPLE_EN, 32'h1);
      chk(pd_ctl[0].en_ra, 1'b1);
      chk(rp_level, 4'h0);
      cc_lvl[0] <= 8'h60;
      wr(OFS_CC_CONTROL, 32'h0d);
      wirq(4000);
      chk(irq, 1'b1);
      rchk(OFS_MATCH, 32'h1);
      wr(OFS_CHG_STS, 32'h1);
      // Line falls below the discharge threshold
      cc_lvl[0] <= 8'h10;
      wt(2);
      wirq(4000);
      chk(irq, 1'b1);
      rchk(OFS_MATCH, 32'h0);
      rchk(OFS_PWR_STS, 32'h8, 32'h8);
      $display("test discharge done");
      wr(OFS_CHG_STS, 32'h11);
      wr(OFS_CC_HW_CONTROL, 32'hb);
      wr(OFS_CC_CONTROL, 32'h415);
      wt(2);
      chk(vconn_fet, 2'h1);
      cc_backdrive <= 2'h1;
      wt(1);
      cc_backdrive <= 2'h0;
      wt(3);
      chk(vconn_fet, 2'h0);
      chk(irq, 1'b1);
      $display("test back-drive done");
      wr(OFS_PWR_STS, 32'h7);
      wr(OFS_CC_HW_CONTROL, 32'h5);
      wt(2);
      chk(vconn_fet, 2'h0);
      // Threshold 0 matched on CC1 only, so the block powers CC1 by itself
      cc_lvl[0] <= 8'h60;
      wirq(4000);
      wt(2);
      chk(vconn_fet, 2'h1);
      $display("test standalone done");
      summarize;
   end
endmodule

// ---- rtl/ccv_pkg.sv ----
/*
 Shared constants and types for the CC detect and VCONN control block.
 Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package ccv_pkg;
   localparam int NTHR = 8;
   localparam int CLK_PERIOD_NS = 50;
   // Dwell on one threshold; two thresholds take about 100 us in all
   localparam int SAMPLE_TIME_NS = 50000;
   localparam int SAMPLE_CYC = SAMPLE_TIME_NS / CLK_PERIOD_NS;
   localparam int UNIT_FAST_NS = 100000;
   localparam int UNIT_SLOW_NS = 1600000;
   localparam int UNIT_FAST_CYC = UNIT_FAST_NS / CLK_PERIOD_NS;
   localparam int UNIT_SLOW_CYC = UNIT_SLOW_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] OFS_CC_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CC_HW_CONTROL = 8'h04;
   localparam logic [7:0] OFS_MATCH_DEBOUNCE_COUNT = 8'h08;
   localparam logic [7:0] OFS_VCONN_FAULT_DEBOUNCE = 8'h0c;
   localparam logic [7:0] OFS_SAMPLE_EN = 8'h10;
   localparam logic [7:0] OFS_MATCH_EN = 8'h18;
   localparam logic [7:0] OFS_DBCLR_EN = 8'h20;
   localparam logic [7:0] OFS_MATCH = 8'h28;
   localparam logic [7:0] OFS_CHG_STS = 8'h30;
   localparam logic [7:0] OFS_PWR_STS = 8'h38;
   localparam logic [7:0] OFS_VBUS_CONTROL = 8'h3c;
   localparam logic [7:0] OFS_THR_BASE = 8'h40;

   // cc_control fields
   localparam int CTL_COMP_LSB = 0;
   localparam int CTL_PD1_LSB = 2;
   localparam int CTL_PD2_LSB = 4;
   localparam int CTL_RP1_LSB = 6;
   localparam int CTL_RP2_LSB = 8;
   localparam int CTL_VCONN_LSB = 10;
   // cc_hardware_control bits
   localparam int HW_UNIT = 0;
   localparam int HW_BLOCK = 1;
   localparam int HW_STANDALONE = 2;
   localparam int HW_AUTO_OFF = 3;
   // power_irq_status bits
   localparam int PS_VCONN_FAULT = 0;
   localparam int PS_BACKDRIVE_LSB = 1;
   localparam int PS_MATCH_VALID = 3;
   // vbus_control fields
   localparam int VB_OCS_EN = 8;
   localparam int VB_ABOVE = 16;

   // Pull-down value codes
   localparam logic [1:0] PD_NONE = 2'h0;
   localparam logic [1:0] PD_TRIM = 2'h1;
   localparam logic [1:0] PD_DEAD_BATT = 2'h2;
   localparam logic [1:0] PD_RA = 2'h3;

   // Dead-battery Rd on both pins after power-up
   localparam logic [11:0] RST_CC_CONTROL = 12'h028;

   typedef struct packed {
      logic en_rd_trim;
      logic dead_battery_pulldown_enable_n;
      logic en_ra;
   } ccv_pd_out_t;

   typedef struct packed {
      logic [7:0] dac_code;
      logic pin;
      logic enable;
   } ccv_comp_ctl_t;
endpackage

// ---- rtl/ccv_top.sv ----
/*
 CC threshold sampling and match debounce, Rd selection, VCONN FET control
 with over-current shutdown, VBUS DAC threshold, AHB-Lite register slave.
 Assumes all pin inputs synchronous to clk and a single AHB-Lite master.
*/
// Summary of operation
// - Rp level per pin is driven straight from the software fields.
// - One selected threshold on one pin can be sampled alone, fast cycle.
// - Per-pin sample enable bits choose thresholds; cleared ones are skipped.
// - With traffic block set, PD activity leaves the match debouncer untouched.
// - Debounce time is count times 1.6 ms, or 100 us when unit bit set.
// - Match enable bits let debounced match changes raise the interrupt.
// - Dead-battery pull-down is selected by default after power-up.
// - Pull-down value fields drive trimmed and dead-battery enable outputs.
// - Each VCONN FET follows its own per-pin control bit.
// - Standalone bit lets the block switch VCONN FETs by itself.
// - Over-current counts only after persisting beyond programmed fault debounce.
// - Detected VCONN over-current sets the fault flag in power status.
// - Optional auto shutoff of VCONN on back-drive or VCONN fault.
// - Debounced over-current turns FETs off and clears VCONN control bits.
// - Debounced comparator changes update match and change status, then interrupt.
// - Match-valid may assert with no threshold matched, meaning discharge done.
// - VBUS sense is compared against an 8-bit DAC threshold.
`timescale 1ns/1ps
module ccv_top
   import ccv_pkg::*;
#(
   parameter int UNIT_FAST = UNIT_FAST_CYC,
   parameter int UNIT_SLOW = UNIT_SLOW_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Analog front end
   input wire logic cc_comp,
   input wire logic pd_busy,
   input wire logic vconn_oc,
   input wire logic [1:0] cc_backdrive,
   input wire logic vbus_comp,
   output ccv_comp_ctl_t cc_comp_ctl,
   output logic [7:0] vbus_dac_code,
   // Termination and VCONN
   output ccv_pd_out_t [1:0] pd_ctl,
   output logic [1:0][1:0] rp_level,
   output logic [1:0] vconn_fet,
   output logic irq
);

   typedef struct packed {
      logic addr_ph;
      logic wr;
      logic [7:0] addr;
      logic ready;
      logic [31:0] rdata;
      logic [11:0] cc_control;
      logic [3:0] hw_control;
      logic [7:0] match_debounce_count;
      logic [7:0] vconn_fault_debounce;
      logic [16:0] vbus_control;
      logic [1:0][7:0] samp_en;
      logic [1:0][7:0] match_en;
      logic [1:0][7:0] dbclr_en;
      logic [1:0][7:0] match;
      logic [1:0][7:0] chg;
      logic [1:0][7:0] raw;
      logic [1:0][7:0] last_raw;
      logic [1:0][8:0] dcnt;
      logic [1:0] settled;
      logic valid;
      logic [NTHR-1:0][7:0] thr;
      logic [2:0] pwr_sts;
      logic [3:0] ptr;
      logic [15:0] sctr;
      logic [15:0] pre;
      logic tick;
      logic [15:0] pref;
      logic tickf;
      logic [8:0] oc_cnt;
      ccv_comp_ctl_t comp;
      ccv_pd_out_t [1:0] pd;
      logic [1:0][1:0] rp;
      logic [1:0] fet;
      logic irq;
   } ccv_state_t;

   ccv_state_t s_reg;
   ccv_state_t s_next;

   function automatic ccv_pd_out_t ccv_pd_decode(input logic [1:0] code);
      ccv_pd_out_t o;
      o.en_rd_trim = (code == PD_TRIM);
      o.dead_battery_pulldown_enable_n = (code != PD_DEAD_BATT);
      o.en_ra = (code == PD_RA);
      return o;
   endfunction

   function automatic logic [31:0] ccv_read(input ccv_state_t s);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (s.addr[7:6] == OFS_THR_BASE[7:6] && s.addr[5] == 1'b0) begin
         d[7:0] = s.thr[s.addr[4:2]];
      end else begin
         case (s.addr)
            OFS_CC_CONTROL: d[11:0] = s.cc_control;
            OFS_CC_HW_CONTROL: d[3:0] = s.hw_control;
            OFS_MATCH_DEBOUNCE_COUNT: d[7:0] = s.match_debounce_count;
            OFS_VCONN_FAULT_DEBOUNCE: d[7:0] = s.vconn_fault_debounce;
            OFS_SAMPLE_EN: d[7:0] = s.samp_en[0];
            OFS_SAMPLE_EN + 8'h04: d[7:0] = s.samp_en[1];
            OFS_MATCH_EN: d[7:0] = s.match_en[0];
            OFS_MATCH_EN + 8'h04: d[7:0] = s.match_en[1];
            OFS_DBCLR_EN: d[7:0] = s.dbclr_en[0];
            OFS_DBCLR_EN + 8'h04: d[7:0] = s.dbclr_en[1];
            OFS_MATCH: d[7:0] = s.match[0];
            OFS_MATCH + 8'h04: d[7:0] = s.match[1];
            OFS_CHG_STS: d[7:0] = s.chg[0];
            OFS_CHG_STS + 8'h04: d[7:0] = s.chg[1];
            OFS_PWR_STS: d[3:0] = {s.valid, s.pwr_sts};
            OFS_VBUS_CONTROL: d[16:0] = s.vbus_control;
            default: d = 32'h0000_0000;
         endcase
      end
      return d;
   endfunction

   logic [15:0] unit_cyc;
   logic blocked;
   logic [7:0] v;
   logic slot_on;

   assign unit_cyc = s_reg.hw_control[HW_UNIT] ? 16'(UNIT_FAST - 1) : 16'(UNIT_SLOW - 1);
   assign blocked = s_reg.hw_control[HW_BLOCK] && pd_busy;
   // Slot is a sampled threshold on a pin the comparator control selects
   assign slot_on = s_reg.samp_en[s_reg.ptr[3]][s_reg.ptr[2:0]] && s_reg.cc_control[s_reg.ptr[3]];

   always_comb begin
      s_next = s_reg;
      v = 8'h00;
      s_next.tick = 1'b0;
      s_next.tickf = 1'b0;

      // Bus data phase: one wait state, read data taken from the current state
      if (s_reg.addr_ph) begin
         s_next.addr_ph = 1'b0;
         s_next.ready = 1'b1;
         if (!s_reg.wr) begin
            s_next.rdata = ccv_read(s_reg);
         end else if (s_reg.addr[7:6] == OFS_THR_BASE[7:6] && s_reg.addr[5] == 1'b0) begin
            s_next.thr[s_reg.addr[4:2]] = hwdata[7:0];
         end else begin
            case (s_reg.addr)
               OFS_CC_CONTROL: s_next.cc_control = hwdata[11:0];
               OFS_CC_HW_CONTROL: s_next.hw_control = hwdata[3:0];
               OFS_MATCH_DEBOUNCE_COUNT: s_next.match_debounce_count = hwdata[7:0];
               OFS_VCONN_FAULT_DEBOUNCE: s_next.vconn_fault_debounce = hwdata[7:0];
               OFS_SAMPLE_EN: s_next.samp_en[0] = hwdata[7:0];
               OFS_SAMPLE_EN + 8'h04: s_next.samp_en[1] = hwdata[7:0];
               OFS_MATCH_EN: s_next.match_en[0] = hwdata[7:0];
               OFS_MATCH_EN + 8'h04: s_next.match_en[1] = hwdata[7:0];
               OFS_DBCLR_EN: s_next.dbclr_en[0] = hwdata[7:0];
               OFS_DBCLR_EN + 8'h04: s_next.dbclr_en[1] = hwdata[7:0];
               OFS_CHG_STS: s_next.chg[0] = s_reg.chg[0] & ~hwdata[7:0];
               OFS_CHG_STS + 8'h04: s_next.chg[1] = s_reg.chg[1] & ~hwdata[7:0];
               OFS_PWR_STS: s_next.pwr_sts = s_reg.pwr_sts & ~hwdata[2:0];
               OFS_VBUS_CONTROL: s_next.vbus_control[8:0] = hwdata[8:0];
               default: s_next.addr = s_reg.addr;
            endcase
         end
      end
      if (hsel && hready && htrans[1] && s_reg.ready) begin
         s_next.addr_ph = 1'b1;
         s_next.ready = 1'b0;
         s_next.wr = hwrite;
         s_next.addr = haddr[7:0];
      end

      // Debounce unit prescalers
      if (s_reg.pre >= unit_cyc) begin
         s_next.pre = 16'h0000;
         s_next.tick = 1'b1;
      end else begin
         s_next.pre = s_reg.pre + 16'h0001;
      end
      if (s_reg.pref >= 16'(UNIT_FAST - 1)) begin
         s_next.pref = 16'h0000;
         s_next.tickf = 1'b1;
      end else begin
         s_next.pref = s_reg.pref + 16'h0001;
      end

      // Threshold scan: skipped slots cost one cycle, enabled ones a full dwell
      if (s_reg.cc_control[1:0] == 2'b00) begin
         s_next.ptr = 4'h0;
         s_next.sctr = 16'h0000;
      end else if (!slot_on) begin
         s_next.ptr = s_reg.ptr + 4'h1;
         s_next.sctr = 16'h0000;
      end else if (s_reg.sctr >= 16'(SAMPLE_CYC - 1)) begin
         // A packet on the line would look like a level change, so drop the sample
         if (!blocked) begin
            s_next.raw[s_reg.ptr[3]][s_reg.ptr[2:0]] = cc_comp;
         end
         s_next.ptr = s_reg.ptr + 4'h1;
         s_next.sctr = 16'h0000;
      end else begin
         s_next.sctr = s_reg.sctr + 16'h0001;
      end
      s_next.comp.dac_code = s_reg.thr[s_reg.ptr[2:0]];
      s_next.comp.pin = s_reg.ptr[3];
      s_next.comp.enable = (s_reg.cc_control[1:0] != 2'b00);

      // Match debounce per pin
      for (int p = 0; p < 2; p++) begin
         v = s_reg.raw[p] & s_reg.dbclr_en[p];
         if (!s_reg.cc_control[p]) begin
            s_next.dcnt[p] = 9'h000;
            s_next.settled[p] = 1'b0;
         end else if (v != s_reg.last_raw[p]) begin
            s_next.last_raw[p] = v;
            s_next.dcnt[p] = 9'h000;
         end else if (blocked) begin
            s_next.dcnt[p] = s_reg.dcnt[p];
         end else if (v != s_reg.match[p] || !s_reg.settled[p]) begin
            if (s_reg.dcnt[p] >= {1'b0, s_reg.match_debounce_count}) begin
               s_next.match[p] = v;
               s_next.chg[p] = s_next.chg[p] | (v ^ s_reg.match[p]);
               s_next.settled[p] = 1'b1;
               s_next.dcnt[p] = 9'h000;
            end else if (s_reg.tick) begin
               s_next.dcnt[p] = s_reg.dcnt[p] + 9'h001;
            end
         end
      end
      // Valid needs only the debounce to finish, not any threshold to match
      s_next.valid = (s_reg.cc_control[1:0] != 2'b00) && ((s_reg.settled | ~s_reg.cc_control[1:0]) == 2'b11);

      // VCONN over-current debounce in 100 us units
      if (s_reg.vbus_control[VB_OCS_EN] && vconn_oc) begin
         if (s_reg.oc_cnt > {1'b0, s_reg.vconn_fault_debounce}) begin
            s_next.pwr_sts[PS_VCONN_FAULT] = 1'b1;
            s_next.cc_control[CTL_VCONN_LSB +: 2] = 2'b00;
         end else if (s_reg.tickf) begin
            s_next.oc_cnt = s_reg.oc_cnt + 9'h001;
         end
      end else begin
         s_next.oc_cnt = 9'h000;
      end
      for (int p = 0; p < 2; p++) begin
         if (cc_backdrive[p]) begin
            s_next.pwr_sts[PS_BACKDRIVE_LSB + p] = 1'b1;
            if (s_reg.hw_control[HW_AUTO_OFF]) begin
               s_next.cc_control[CTL_VCONN_LSB +: 2] = 2'b00;
            end
         end
      end
      if (s_reg.hw_control[HW_AUTO_OFF] && s_reg.pwr_sts[PS_VCONN_FAULT]) begin
         s_next.cc_control[CTL_VCONN_LSB +: 2] = 2'b00;
      end

      // FETs: software bits, or in standalone the pin that shows Ra
      for (int p = 0; p < 2; p++) begin
         if (s_reg.hw_control[HW_STANDALONE]) begin
            s_next.fet[p] = s_reg.match[p][0] && !s_reg.match[p][1] && !s_reg.pwr_sts[PS_VCONN_FAULT]
                            && !(s_reg.hw_control[HW_AUTO_OFF] && (s_reg.pwr_sts[2:1] != 2'b00));
         end else begin
            s_next.fet[p] = s_next.cc_control[CTL_VCONN_LSB + p];
         end
      end

      // Termination outputs
      s_next.pd[0] = ccv_pd_decode(s_reg.cc_control[CTL_PD1_LSB +: 2]);
      s_next.pd[1] = ccv_pd_decode(s_reg.cc_control[CTL_PD2_LSB +: 2]);
      s_next.rp[0] = s_reg.cc_control[CTL_RP1_LSB +: 2];
      s_next.rp[1] = s_reg.cc_control[CTL_RP2_LSB +: 2];
      s_next.vbus_control[VB_ABOVE] = vbus_comp;

      s_next.irq = ((s_reg.chg[0] & s_reg.match_en[0]) != 8'h00)
                   || ((s_reg.chg[1] & s_reg.match_en[1]) != 8'h00)
                   || (s_reg.pwr_sts != 3'b000);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.ready <= 1'b1;
         s_reg.cc_control <= RST_CC_CONTROL;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from state flops; hresp tied low
   assign hrdata = s_reg.rdata;
   assign hreadyout = s_reg.ready;
   assign hresp = 1'b0;
   assign cc_comp_ctl = s_reg.comp;
   assign vbus_dac_code = s_reg.vbus_control[7:0];
   assign pd_ctl = s_reg.pd;
   assign rp_level = s_reg.rp;
   assign vconn_fet = s_reg.fet;
   assign irq = s_reg.irq;

endmodule
